// ===== rtl/wiecd_pkg.sv
// Package for the wide immediate expand and control decode block.
// Assumes a 32-bit instruction presented as two halfwords, first halfword in hw1.
// Operation
// - 32-bit encoding valid only when first-halfword class field is nonzero.
// - Top immediate bits zero: bits 9:8 pick zero-extend or byte replication pattern.
// - Replicating patterns with a zero low byte flag the result unpredictable.
// - Otherwise rotate one-prefixed seven bits right by immediate bits 11:7.
// - Logical flag-setting op keeps carry for selector 00xxx, else takes bit 31.
// - Plain immediate: add, subtract (PC-relative with base 1111), move, move top.
// - Saturates; dual forms when second-halfword bits zero and DSP variant present.
// - Signed and unsigned field extract; insert, or clear when base is 1111.
// - Branch space: conditional, unconditional branch and branch with link by selector.
// - Special register write and read; permanent undefined at selector 010.
// - Opcodes 0111010 and 0111011 route to hint and misc-control decoders.
// - Hint space: nonzero first selector undefined, else listed hints by second selector.
// - Unallocated hint encodings execute as no-operations.
// - Misc control: clear exclusive, memory barrier, instruction sync barrier.
// - Opcode 0100 option picks store-bypass, physical store-bypass or data sync barrier.
// - Unallocated misc-control encodings are undefined.
package wiecd_pkg;

  localparam logic [2:0] WIECD_WIDE_PREFIX   = 3'h7;
  localparam logic [1:0] WIECD_CLASS_16BIT   = 2'h0;
  localparam logic [1:0] WIECD_CLASS_DP      = 2'h2;
  localparam logic [1:0] WIECD_IMM_UNROT     = 2'h0;
  localparam logic [1:0] WIECD_REP_ZEXT      = 2'h0;
  localparam logic [1:0] WIECD_REP_02        = 2'h1;
  localparam logic [1:0] WIECD_REP_13        = 2'h2;
  localparam logic [1:0] WIECD_REP_ALL       = 2'h3;
  localparam logic [3:0] WIECD_REG_PC        = 4'hf;

  localparam logic [4:0] WIECD_OP_ADDW       = 5'h00;
  localparam logic [4:0] WIECD_OP_MOVW       = 5'h04;
  localparam logic [4:0] WIECD_OP_SUBW       = 5'h0a;
  localparam logic [4:0] WIECD_OP_MOVE_TOP   = 5'h0c;
  localparam logic [4:0] WIECD_OP_SAT_S      = 5'h10;
  localparam logic [4:0] WIECD_OP_SAT_S_D    = 5'h12;
  localparam logic [4:0] WIECD_OP_EXT_S      = 5'h14;
  localparam logic [4:0] WIECD_OP_INSERT     = 5'h16;
  localparam logic [4:0] WIECD_OP_SAT_U      = 5'h18;
  localparam logic [4:0] WIECD_OP_SAT_U_D    = 5'h1a;
  localparam logic [4:0] WIECD_OP_EXT_U      = 5'h1c;

  localparam logic [6:0] WIECD_BR_SREG_WR    = 7'h38;
  localparam logic [6:0] WIECD_BR_HINT       = 7'h3a;
  localparam logic [6:0] WIECD_BR_MISC       = 7'h3b;
  localparam logic [6:0] WIECD_BR_SREG_RD    = 7'h3e;
  localparam logic [6:0] WIECD_BR_PERM_UND   = 7'h7f;
  localparam logic [6:0] WIECD_BR_CONDMASK   = 7'h38;
  localparam logic [2:0] WIECD_SEL_PERM_UND  = 3'h2;

  localparam logic [7:0] WIECD_HINT_NOP      = 8'h00;
  localparam logic [7:0] WIECD_HINT_YIELD    = 8'h01;
  localparam logic [7:0] WIECD_HINT_WAIT_EV  = 8'h02;
  localparam logic [7:0] WIECD_HINT_WAIT_IRQ = 8'h03;
  localparam logic [7:0] WIECD_HINT_SEND_EV  = 8'h04;
  localparam logic [7:0] WIECD_HINT_SPEC_BAR = 8'h14;
  localparam logic [3:0] WIECD_HINT_DEBUG_HI = 4'hf;

  localparam logic [3:0] WIECD_MC_CLEAR_EX   = 4'h2;
  localparam logic [3:0] WIECD_MC_SYNC_BAR   = 4'h4;
  localparam logic [3:0] WIECD_MC_MEM_BAR    = 4'h5;
  localparam logic [3:0] WIECD_MC_INSN_BAR   = 4'h6;
  localparam logic [3:0] WIECD_OPT_BYPASS    = 4'h0;
  localparam logic [3:0] WIECD_OPT_PHYS_BYP  = 4'h4;

  typedef enum logic [5:0] {
    WIECD_NONE           = 6'h00, WIECD_ADD_WIDE     = 6'h01, WIECD_SUB_WIDE      = 6'h02,
    WIECD_PC_REL_ADDR    = 6'h03, WIECD_MOVE_WIDE    = 6'h04, WIECD_MOVE_TOP_HALF = 6'h05,
    WIECD_SIGNED_SAT     = 6'h06, WIECD_UNSIGNED_SAT = 6'h07, WIECD_DUAL_SIGNED_SAT = 6'h08,
    WIECD_DUAL_UNSIGNED_SAT = 6'h09, WIECD_SIGNED_FIELD_EXTRACT = 6'h0a,
    WIECD_UNSIGNED_FIELD_EXTRACT = 6'h0b, WIECD_FIELD_INSERT = 6'h0c,
    WIECD_FIELD_CLEAR    = 6'h0d, WIECD_COND_BRANCH  = 6'h0e, WIECD_BRANCH        = 6'h0f,
    WIECD_BRANCH_WITH_LINK = 6'h10, WIECD_SPECIAL_REG_WRITE = 6'h11,
    WIECD_SPECIAL_REG_READ = 6'h12, WIECD_PERMANENT_UNDEFINED = 6'h13,
    WIECD_NOP_HINT       = 6'h14, WIECD_YIELD_HINT   = 6'h15, WIECD_WAIT_EVENT_HINT = 6'h16,
    WIECD_WAIT_INTERRUPT_HINT = 6'h17, WIECD_SEND_EVENT_HINT = 6'h18,
    WIECD_SPECULATIVE_DATA_BARRIER = 6'h19, WIECD_DEBUG_HINT = 6'h1a,
    WIECD_CLEAR_EXCLUSIVE_MONITOR = 6'h1b, WIECD_DATA_MEMORY_BARRIER = 6'h1c,
    WIECD_INSTRUCTION_SYNC_BARRIER = 6'h1d, WIECD_DATA_SYNC_BARRIER = 6'h1e,
    WIECD_STORE_BYPASS_BARRIER = 6'h1f, WIECD_PHYSICAL_STORE_BYPASS_BARRIER = 6'h20,
    WIECD_MODIFIED_IMM_DP = 6'h21, WIECD_UNDEFINED   = 6'h22
  } wiecd_class_t;

  typedef struct packed {
    logic [31:0] value;
    logic        carry_out;
    logic        unpredictable;
  } wiecd_imm_t;

endpackage : wiecd_pkg

// ===== rtl/wiecd_imm_expand.sv
// Wide immediate expander: 12-bit packed immediate to 32-bit constant and carry.
// Purely combinational; caller supplies the current carry flag.
`timescale 1ns/1ps
module wiecd_imm_expand
  import wiecd_pkg::*;
(
  input  wire logic [11:0] packed_immediate_field,
  input  wire logic        carry_in,
  output wiecd_imm_t       imm_out
);

  wire logic [7:0]  low_byte  = packed_immediate_field[7:0];
  wire logic        is_unrot  = packed_immediate_field[11:10] == WIECD_IMM_UNROT;
  wire logic [1:0]  rep_sel   = packed_immediate_field[9:8];
  wire logic [4:0]  rot_amt   = packed_immediate_field[11:7];
  wire logic [31:0] unrot_val = {24'h000000, 1'b1, packed_immediate_field[6:0]};
  wire logic [63:0] doubled   = {unrot_val, unrot_val};
  wire logic [31:0] rotated   = doubled[rot_amt +: 32];
  wire logic [31:0] rep_val   =
      (rep_sel == WIECD_REP_ZEXT) ? {24'h000000, low_byte} :
      (rep_sel == WIECD_REP_02)   ? {8'h00, low_byte, 8'h00, low_byte} :
      (rep_sel == WIECD_REP_13)   ? {low_byte, 8'h00, low_byte, 8'h00} :
                                    {4{low_byte}};

  assign imm_out.value         = is_unrot ? rep_val : rotated;
  // Rotate carry is bit 31 of the rotated result
  assign imm_out.carry_out     = is_unrot ? carry_in : rotated[31];
  assign imm_out.unpredictable = is_unrot && (rep_sel != WIECD_REP_ZEXT)
                                 && (low_byte == 8'h00);

endmodule : wiecd_imm_expand

// ===== rtl/wiecd_decode.sv
// Decode of modified-immediate, plain-immediate and branch/control 32-bit encodings.
// Assumes halfwords are stable for the cycle; outputs settle combinationally.
`timescale 1ns/1ps
module wiecd_decode
  import wiecd_pkg::*;
#(
  parameter bit DSP_EXT = 1'b1
)(
  input  wire logic [15:0] hw1,
  input  wire logic [15:0] hw2,
  input  wire logic        program_status_flags_c,
  input  wire logic        logical_set_flags,
  output wiecd_class_t     insn_class,
  output wiecd_imm_t       imm_info,
  output logic             carry_next,
  output logic             undefined_insn,
  output logic             unpredictable_insn
);

  // ------------------------------------------------------------
  // Field extraction
  // ------------------------------------------------------------
  wire logic        is_wide   = (hw1[15:13] == WIECD_WIDE_PREFIX)
                                && (hw1[12:11] != WIECD_CLASS_16BIT);
  wire logic        sp_dp     = is_wide && (hw1[12:11] == WIECD_CLASS_DP);
  wire logic        sp_modimm = sp_dp && !hw2[15] && !hw1[9];
  wire logic        sp_plain  = sp_dp && !hw2[15] && hw1[9];
  wire logic        sp_branch = sp_dp && hw2[15];
  wire logic [4:0]  plain_op  = hw1[8:4];
  wire logic [3:0]  base_reg  = hw1[3:0];
  wire logic        base_pc   = base_reg == WIECD_REG_PC;
  wire logic [6:0]  br_op     = hw1[10:4];
  wire logic [2:0]  br_sel    = hw2[14:12];
  wire logic [2:0]  hint_sel1 = hw2[10:8];
  wire logic [7:0]  hint_sel2 = hw2[7:0];
  wire logic [3:0]  mc_op     = hw2[7:4];
  wire logic [3:0]  mc_option = hw2[3:0];
  wire logic [11:0] immediate_field = {hw1[10], hw2[14:12], hw2[7:0]};
  wire logic [4:0]  carry_sel = immediate_field[11:7];
  wire logic        dual_form = (hw2[14:12] == 3'h0) && (hw2[7:6] == 2'h0) && DSP_EXT;

  // ------------------------------------------------------------
  // Immediate expansion
  // ------------------------------------------------------------
  wiecd_imm_expand u_expand (
    .packed_immediate_field (immediate_field),
    .carry_in               (program_status_flags_c),
    .imm_out                (imm_info)
  );

  // Only logical flag-setting ops move carry; others leave it for the ALU
  assign carry_next = (logical_set_flags && sp_modimm && carry_sel[4:3] != 2'h0)
                      ? imm_info.value[31] : program_status_flags_c;
  assign unpredictable_insn = sp_modimm && imm_info.unpredictable;

  // ------------------------------------------------------------
  // Plain binary immediate
  // ------------------------------------------------------------
  wiecd_class_t plain_class;
  always_comb begin
    case (plain_op)
      WIECD_OP_ADDW:   plain_class = base_pc ? WIECD_PC_REL_ADDR : WIECD_ADD_WIDE;
      WIECD_OP_SUBW:   plain_class = base_pc ? WIECD_PC_REL_ADDR : WIECD_SUB_WIDE;
      WIECD_OP_MOVW:   plain_class = WIECD_MOVE_WIDE;
      WIECD_OP_MOVE_TOP: plain_class = WIECD_MOVE_TOP_HALF;
      WIECD_OP_SAT_S:    plain_class = WIECD_SIGNED_SAT;
      WIECD_OP_SAT_U:    plain_class = WIECD_UNSIGNED_SAT;
      WIECD_OP_SAT_S_D:  plain_class = dual_form ? WIECD_DUAL_SIGNED_SAT
                                                 : WIECD_SIGNED_SAT;
      WIECD_OP_SAT_U_D:  plain_class = dual_form ? WIECD_DUAL_UNSIGNED_SAT
                                                 : WIECD_UNSIGNED_SAT;
      WIECD_OP_EXT_S:    plain_class = WIECD_SIGNED_FIELD_EXTRACT;
      WIECD_OP_EXT_U:    plain_class = WIECD_UNSIGNED_FIELD_EXTRACT;
      WIECD_OP_INSERT:   plain_class = base_pc ? WIECD_FIELD_CLEAR
                                               : WIECD_FIELD_INSERT;
      default:         plain_class = WIECD_UNDEFINED;
    endcase
  end

  // ------------------------------------------------------------
  // Hint and miscellaneous control
  // ------------------------------------------------------------
  wiecd_class_t hint_class;
  always_comb begin
    if (hint_sel1 != 3'h0) begin
      hint_class = WIECD_UNDEFINED;
    end else if (hint_sel2[7:4] == WIECD_HINT_DEBUG_HI) begin
      hint_class = WIECD_DEBUG_HINT;
    end else begin
      case (hint_sel2)
        WIECD_HINT_NOP:   hint_class = WIECD_NOP_HINT;
        WIECD_HINT_YIELD: hint_class = WIECD_YIELD_HINT;
        WIECD_HINT_WAIT_EV:  hint_class = WIECD_WAIT_EVENT_HINT;
        WIECD_HINT_WAIT_IRQ: hint_class = WIECD_WAIT_INTERRUPT_HINT;
        WIECD_HINT_SEND_EV:  hint_class = WIECD_SEND_EVENT_HINT;
        WIECD_HINT_SPEC_BAR: hint_class = WIECD_SPECULATIVE_DATA_BARRIER;
        // Reserved hints behave as no-ops rather than trapping
        default:          hint_class = WIECD_NOP_HINT;
      endcase
    end
  end

  wiecd_class_t misc_class;
  always_comb begin
    case (mc_op)
      WIECD_MC_CLEAR_EX: misc_class = WIECD_CLEAR_EXCLUSIVE_MONITOR;
      WIECD_MC_MEM_BAR:  misc_class = WIECD_DATA_MEMORY_BARRIER;
      WIECD_MC_INSN_BAR: misc_class = WIECD_INSTRUCTION_SYNC_BARRIER;
      WIECD_MC_SYNC_BAR: begin
        case (mc_option)
          WIECD_OPT_BYPASS:   misc_class = WIECD_STORE_BYPASS_BARRIER;
          WIECD_OPT_PHYS_BYP: misc_class = WIECD_PHYSICAL_STORE_BYPASS_BARRIER;
          default:         misc_class = WIECD_DATA_SYNC_BARRIER;
        endcase
      end
      default:        misc_class = WIECD_UNDEFINED;
    endcase
  end

  // ------------------------------------------------------------
  // Branches and control
  // ------------------------------------------------------------
  wiecd_class_t br_class;
  always_comb begin
    if (br_sel[0]) begin
      br_class = br_sel[2] ? WIECD_BRANCH_WITH_LINK : WIECD_BRANCH;
    end else if (br_sel == WIECD_SEL_PERM_UND && br_op == WIECD_BR_PERM_UND) begin
      br_class = WIECD_PERMANENT_UNDEFINED;
    end else if (br_sel[2]) begin
      br_class = WIECD_UNDEFINED;
    end else if ((br_op & WIECD_BR_CONDMASK) != WIECD_BR_CONDMASK) begin
      br_class = WIECD_COND_BRANCH;
    end else begin
      case (br_op)
        WIECD_BR_SREG_WR, WIECD_BR_SREG_WR | 7'h01: br_class = WIECD_SPECIAL_REG_WRITE;
        WIECD_BR_SREG_RD, WIECD_BR_SREG_RD | 7'h01: br_class = WIECD_SPECIAL_REG_READ;
        WIECD_BR_HINT:                      br_class = hint_class;
        WIECD_BR_MISC:                      br_class = misc_class;
        default:                            br_class = WIECD_UNDEFINED;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Final class and undefined indication
  // ------------------------------------------------------------
  assign insn_class = sp_branch ? br_class :
                      sp_plain  ? plain_class :
                      sp_modimm ? WIECD_MODIFIED_IMM_DP : WIECD_NONE;
  assign undefined_insn = (insn_class == WIECD_UNDEFINED)
                          || (insn_class == WIECD_PERMANENT_UNDEFINED);

endmodule : wiecd_decode

// ===== testbench/wiecd_decode_properties.sv
// Checker for the decode block: ties decoded outputs to the halfwords.
// Assumes the bench clock and reset reach it through the bind below.
`timescale 1ns/1ps
module wiecd_decode_properties
  import wiecd_pkg::*;
(
  input wire logic   clk_sys,
  input wire logic   rst_n,
  input wire logic   [15:0] hw1,
  input wire logic   [15:0] hw2,
  input wire logic   program_status_flags_c,
  input wire logic   logical_set_flags,
  input wiecd_class_t insn_class,
  input wiecd_imm_t  imm_info,
  input wire logic   carry_next,
  input wire logic   undefined_insn
);
  wire [11:0] imm   = {hw1[10], hw2[14:12], hw2[7:0]};
  wire [63:0] dbl   = {2{24'h0, 1'b1, imm[6:0]}};
  wire [63:0] rot   = dbl >> imm[11:7];
  wire        dp    = hw1[15:11] == 5'h1e;
  wire        modi  = dp && !hw2[15] && !hw1[9];
  wire        plain = dp && !hw2[15] && hw1[9];
  wire        br    = dp && hw2[15];
  wire [6:0]  bop   = hw1[10:4];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  short_insn_a: assert property (
    hw1[12:11] == 2'h0 |-> insn_class == WIECD_NONE && !undefined_insn) else $error("short form");
  zext_imm_a: assert property (
    imm[11:8] == 4'h0 |-> imm_info.value == {24'h0, imm[7:0]}) else $error("zero extend");
  rep_zero_a: assert property (
    imm[11:10] == 2'h0 && imm[9:8] != 2'h0 && imm[7:0] == 8'h00 |-> imm_info.unpredictable)
    else $error("zero byte pattern");
  rotate_a: assert property (
    imm[11:10] != 2'h0 |-> imm_info.value == rot[31:0]) else $error("rotation");
  carry_sel_a: assert property (
    modi && logical_set_flags |-> carry_next == (imm[11:10] == 2'h0 ?
      program_status_flags_c : imm_info.value[31])) else $error("carry out");
  pc_rel_a: assert property (
    plain && (hw1[8:4] == 5'h00 || hw1[8:4] == 5'h0a) && hw1[3:0] == 4'hf
      |-> insn_class == WIECD_PC_REL_ADDR) else $error("pc relative");
  perm_undef_a: assert property (
    br && hw2[14:12] == 3'h2 && bop == 7'h7f |-> insn_class == WIECD_PERMANENT_UNDEFINED
      && undefined_insn) else $error("permanent undefined");
  misc_undef_a: assert property (
    br && !hw2[14] && !hw2[12] && bop == 7'h3b && !(hw2[7:4] inside {4'h2, 4'h4, 4'h5, 4'h6})
      |-> insn_class == WIECD_UNDEFINED) else $error("misc undefined");
  settle_a: assert property (
    $stable({hw1, hw2, program_status_flags_c, logical_set_flags})
      |-> $stable({insn_class, imm_info, carry_next})) else $error("output moved");

  cover property (br && hw2[14] && hw2[12]);
  cover property (imm_info.unpredictable);
  cover property (insn_class == WIECD_PC_REL_ADDR);
endmodule : wiecd_decode_properties

bind wiecd_decode wiecd_decode_properties i_wiecd_decode_properties (
  .clk_sys(wiecd_decode_bench.clk_sys), .rst_n(wiecd_decode_bench.rst_n), .hw1(hw1),
  .hw2(hw2), .program_status_flags_c(program_status_flags_c),
  .logical_set_flags(logical_set_flags), .insn_class(insn_class), .imm_info(imm_info),
  .carry_next(carry_next), .undefined_insn(undefined_insn));

// ===== testbench/wiecd_fetch_model.sv
// Fetch stage model: presents halfwords and status flags to the decoder.
// Assumes the bench loads its requests on falling edges.
`timescale 1ns/1ps
module wiecd_fetch_model
  import wiecd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [31:0] fetch_word,
  input  wire logic        carry_set,
  input  wire logic        logical_op,
  output logic      [15:0] hw1,
  output logic      [15:0] hw2,
  output logic             program_status_flags_c,
  output logic             logical_set_flags
);
  // Falling-edge launch so the decoder settles before the sampling edge
  always @(negedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hw1 <= 16'h0000; // Idle as a short-form word
      hw2 <= 16'h0000;
      program_status_flags_c <= 1'b0;
      logical_set_flags <= 1'b0;
    end else begin
      hw1 <= fetch_word[31:16]; // First halfword travels in hw1
      hw2 <= fetch_word[15:0];
      program_status_flags_c <= carry_set;
      logical_set_flags <= logical_op;
    end
  end
endmodule : wiecd_fetch_model

// ===== testbench/wiecd_decode_bench.sv
// Self-checking bench for the decode block, fed by the fetch stage model.
// Assumes the checker is bound to the decoder and reads clk_sys and rst_n here.
`timescale 1ns/1ps
module wiecd_decode_bench;
  import wiecd_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rst_n = 1'b0;
  logic  [31:0] fetch_word = 32'h0;
  logic         carry_set = 1'b0;
  logic         logical_op = 1'b0;
  logic  [15:0] hw1, hw2;
  logic         program_status_flags_c, logical_set_flags, carry_next, undefined_insn;
  logic         unpredictable_insn;
  wiecd_class_t insn_class;
  wiecd_imm_t   imm_info;
  int           fail_count = 0;
  int           check_count = 0;

  always #5 clk_sys = ~clk_sys;

  wiecd_fetch_model i_wiecd_fetch_model (.clk_sys, .rst_n, .fetch_word, .carry_set,
    .logical_op, .hw1, .hw2, .program_status_flags_c, .logical_set_flags);
  wiecd_decode i_wiecd_decode (.hw1, .hw2, .program_status_flags_c, .logical_set_flags,
    .insn_class, .imm_info, .carry_next, .undefined_insn, .unpredictable_insn);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic present(input logic [31:0] w, input logic c, input logic l);
    @(negedge clk_sys);
    fetch_word <= w;
    carry_set <= c;
    logical_op <= l;
    @(negedge clk_sys);
    @(posedge clk_sys);
    #1;
  endtask : present

  task automatic decode(input logic [31:0] w, input wiecd_class_t cls);
    present(w, 1'b0, 1'b0);
    check(insn_class, cls);
    check(undefined_insn, cls inside {WIECD_UNDEFINED, WIECD_PERMANENT_UNDEFINED});
    check(unpredictable_insn, 1'b0);
  endtask : decode

  task automatic test_immediates();
    logic [11:0] m[8] = '{12'h0ab, 12'h1ab, 12'h2ab, 12'h3ab, 12'h100, 12'h300, 12'h4ab, 12'hfff};
    logic [31:0] u, v;
    foreach (m[k]) begin
      u = {24'h0, 1'b1, m[k][6:0]};
      case (m[k][11:8])
        4'h0: v = {24'h0, m[k][7:0]};
        4'h1: v = {2{8'h0, m[k][7:0]}};
        4'h2: v = {2{m[k][7:0], 8'h0}};
        4'h3: v = {4{m[k][7:0]}};
        default: v = 32'({u, u} >> m[k][11:7]);
      endcase
      present({5'h1e, m[k][11], 10'h0, 1'b0, m[k][10:8], 4'h0, m[k][7:0]}, k[0], 1'b1);
      check(imm_info.value, v);
      check(imm_info.unpredictable, m[k][11:10] == 0 && m[k][9:8] != 0 && m[k][7:0] == 0);
      check(unpredictable_insn, m[k][11:10] == 0 && m[k][9:8] != 0 && m[k][7:0] == 0);
      check(carry_next, m[k][11:10] == 0 ? k[0] : v[31]);
      check(imm_info.carry_out, m[k][11:10] == 0 ? k[0] : v[31]);
    end
    // Rotated constant with bit 31 clear, but not a logical op: carry must hold
    present(32'hf40070ff, 1'b1, 1'b0);
    check(carry_next, 1'b1);
    $display("immediate expansion done");
  endtask : test_immediates

  task automatic test_plain();
    logic [31:0] w[14] = '{32'hf2000000, 32'hf20f0000, 32'hf2a00000, 32'hf2af0000, 32'hf2400000,
      32'hf2c00000, 32'hf3000000, 32'hf3200000, 32'hf3a00040, 32'hf3a00000, 32'hf3400000,
      32'hf3c00000, 32'hf3600000, 32'hf36f0000};
    wiecd_class_t c[14] = '{WIECD_ADD_WIDE, WIECD_PC_REL_ADDR, WIECD_SUB_WIDE, WIECD_PC_REL_ADDR,
      WIECD_MOVE_WIDE, WIECD_MOVE_TOP_HALF, WIECD_SIGNED_SAT, WIECD_DUAL_SIGNED_SAT,
      WIECD_UNSIGNED_SAT, WIECD_DUAL_UNSIGNED_SAT, WIECD_SIGNED_FIELD_EXTRACT,
      WIECD_UNSIGNED_FIELD_EXTRACT, WIECD_FIELD_INSERT, WIECD_FIELD_CLEAR};
    foreach (w[k]) decode(w[k], c[k]);
    decode(32'hf3800000, WIECD_UNSIGNED_SAT);
    decode(32'hf3201000, WIECD_SIGNED_SAT);
    decode(32'hf2200000, WIECD_UNDEFINED);
    decode(32'hf04f0000, WIECD_MODIFIED_IMM_DP);
    decode(32'he7fff04f, WIECD_NONE);
    $display("plain immediate done");
  endtask : test_plain

  task automatic test_control();
    logic [31:0] w[15] = '{32'hf000a000, 32'hf000b000, 32'hf000d000, 32'hf3908000, 32'hf3e08000,
      32'hf7f0a000, 32'hf3af8003, 32'hf3af8014, 32'hf3af80f5, 32'hf3af8005, 32'hf3af8100,
      32'hf3bf8f2f, 32'hf3bf8f44, 32'hf3bf8f41, 32'hf3bf8f0f};
    wiecd_class_t c[15] = '{WIECD_COND_BRANCH, WIECD_BRANCH, WIECD_BRANCH_WITH_LINK,
      WIECD_SPECIAL_REG_WRITE, WIECD_SPECIAL_REG_READ, WIECD_PERMANENT_UNDEFINED,
      WIECD_WAIT_INTERRUPT_HINT, WIECD_SPECULATIVE_DATA_BARRIER, WIECD_DEBUG_HINT,
      WIECD_NOP_HINT, WIECD_UNDEFINED, WIECD_CLEAR_EXCLUSIVE_MONITOR,
      WIECD_PHYSICAL_STORE_BYPASS_BARRIER, WIECD_DATA_SYNC_BARRIER, WIECD_UNDEFINED};
    foreach (w[k]) decode(w[k], c[k]);
    decode(32'hf3af8001, WIECD_YIELD_HINT);
    decode(32'hf3af8002, WIECD_WAIT_EVENT_HINT);
    decode(32'hf3af8004, WIECD_SEND_EVENT_HINT);
    decode(32'hf3af8000, WIECD_NOP_HINT);
    decode(32'hf000c000, WIECD_UNDEFINED);
    decode(32'hf3bf8f40, WIECD_STORE_BYPASS_BARRIER);
    decode(32'hf3bf8f5f, WIECD_DATA_MEMORY_BARRIER);
    decode(32'hf3bf8f6f, WIECD_INSTRUCTION_SYNC_BARRIER);
    $display("branch and control done");
  endtask : test_control

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n <= 1'b1;
    test_immediates();
    test_plain();
    test_control();
    give_verdict();
  end
endmodule : wiecd_decode_bench
